// *** src/amip_bank.sv ***
// motion parameter bank with apb slave, detectors and interrupt
`timescale 1ns/100ps
module amip_bank #(
	parameter int SAMPLE_HZ = 100,    // evaluated samples per second
	parameter int CNT_W     = 24      // sample counter width
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     clk_en,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [amip_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire amip_pkg::amip_sample_s   sample,
	input  wire logic [2:0]               orient_code,
	output logic                          irq,
	output amip_pkg::amip_knock_s         knock_cfg,
	output amip_pkg::amip_tilt_s          tilt_cfg
);
	import amip_pkg::*;

	// ************************************************************
	// parameter check
	// ************************************************************
	if (SAMPLE_HZ < 1 || SAMPLE_HZ > 4000 || CNT_W < 20 || CNT_W > 31) begin : g_chk
		$error("amip_bank: SAMPLE_HZ or CNT_W out of range");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0]         high_lvl;     // high_g_level_cfg
		logic [7:0]         mot_dur;      // motion_duration_cfg
		logic [7:0]         any_lvl;      // anymotion_level_cfg
		logic [7:0]         still_lvl;    // stillness_level_cfg
		logic [7:0]         knock_time;   // knock_timing_cfg
		logic [7:0]         knock_lvl;    // knock_level_cfg
		logic [7:0]         tilt_hb;      // tilt_hysteresis_block_cfg
		logic [7:0]         tilt_ud;      // tilt_updown_angle_cfg
		logic [7:0]         flat_ang;     // level_angle_cfg
		logic [7:0]         ctrl;         // range and stillness select
		logic [7:0]         stat;         // sticky events
		logic [7:0]         mask;         // interrupt mask
		logic [31:0]        rdata;        // read data
		logic               have_prev;    // previous sample stored
		logic signed [11:0] px;
		logic signed [11:0] py;
		logic signed [11:0] pz;
		logic [1:0]         any_run;      // consecutive any-motion samples
		logic [1:0]         slow_run;     // consecutive slow-motion samples
		logic [CNT_W-1:0]   still_cnt;    // quiet samples
		logic [2:0]         orient_prev;  // last orientation code
		logic [CNT_W-1:0]   stable_cnt;   // samples orientation unchanged
		amip_knock_s        knock;
		amip_tilt_s         tilt;
	} amip_state_s;

	// reset image of the whole state
	function automatic amip_state_s init_state();
		amip_state_s s;
		s = '0;
		s.high_lvl   = RST_HIGH_LVL;
		s.mot_dur    = RST_MOT_DUR;
		s.any_lvl    = RST_ANY_LVL;
		s.still_lvl  = RST_STILL_LVL;
		s.knock_time = RST_KNOCK_TIME;
		s.knock_lvl  = RST_KNOCK_LVL;
		s.tilt_hb    = RST_TILT_HB;
		s.tilt_ud    = RST_TILT_UD;
		s.flat_ang   = RST_FLAT_ANG;
		s.tilt.mode  = AMIP_TILT_SYM;
		return s;
	endfunction

	localparam amip_state_s RST_STATE = init_state();

	amip_state_s q;   // registered state
	amip_state_s d;   // next state

	// ************************************************************
	// helpers
	// ************************************************************
	// milliseconds to samples, at least one
	function automatic logic [15:0] ms_to_smp(input int ms);
		int n;
		n = (ms * SAMPLE_HZ) / MS_PER_S;
		if (n < 1) begin
			n = 1;
		end
		return n[15:0];
	endfunction

	// magnitude of a 13-bit signed value
	function automatic logic [15:0] mag(input logic signed [12:0] v);
		logic [12:0] m;
		m = v[12] ? 13'(-v) : 13'(v);
		return {3'h0, m};
	endfunction

	// field value weighted into data lsb
	function automatic logic [15:0] weigh(input logic [7:0] v, input int sh);
		return 16'({8'h00, v} << sh);
	endfunction

	// range-dependent constant in data lsb of the selected range
	function automatic logic [15:0] by_range(input logic [15:0] v, input logic [1:0] r);
		return v >> r;
	endfunction

	// double-knock window in ms
	function automatic int win_ms(input logic [2:0] c);
		case (c)
			3'h0:    return 50;
			3'h1:    return 100;
			3'h2:    return 150;
			3'h3:    return 200;
			3'h4:    return 250;
			3'h5:    return 375;
			3'h6:    return 500;
			default: return 700;
		endcase
	endfunction

	// no-motion delay in seconds
	function automatic logic [8:0] still_s(input logic [5:0] c);
		if (c[5]) begin
			return 9'({4'h0, c[4:0]} * 9'd8 + 9'd88);
		end else if (c[4]) begin
			return 9'({5'h0, c[3:0]} * 9'd4 + 9'd20);
		end else begin
			return 9'({5'h0, c[3:0]} + 9'd1);
		end
	endfunction

	// ************************************************************
	// combinational next state
	// ************************************************************
	logic             acc;        // apb access phase, clock enabled
	logic             setup;      // apb setup phase
	logic             mapped;     // address hits a register
	logic [5:0]       idx;        // word index
	logic [7:0]       wb;         // write byte
	logic [7:0]       rb;         // read byte
	logic [7:0]       ev;         // events of this cycle
	logic [1:0]       rng;        // range code
	logic [15:0]      sx;         // slope per axis
	logic [15:0]      sy;
	logic [15:0]      sz;
	logic [15:0]      smax;       // largest slope
	logic [15:0]      amax;       // largest magnitude
	logic [CNT_W-1:0] still_tgt;  // no-motion target in samples
	logic [CNT_W-1:0] stab_tgt;   // stable orientation target

	always_comb begin
		d      = q;
		ev     = 8'h00;
		idx    = paddr[ADDR_W-1:2];
		wb     = pwdata[7:0];
		rng    = q.ctrl[CTRL_RANGE_LO +: 2];
		setup  = psel & ~penable;
		acc    = psel & penable & clk_en;
		mapped = (paddr[1:0] == 2'h0) &&
			((idx >= IDX_HIGH_LVL && idx <= IDX_FLAT_ANG) ||
			 (idx >= IDX_CTRL && idx <= IDX_MASK));
		// slope and magnitude of the present sample
		sx   = mag(13'(sample.x) - 13'(q.px));
		sy   = mag(13'(sample.y) - 13'(q.py));
		sz   = mag(13'(sample.z) - 13'(q.pz));
		smax = (sx > sy) ? sx : sy;
		smax = (sz > smax) ? sz : smax;
		amax = (mag(13'(sample.x)) > mag(13'(sample.y))) ? mag(13'(sample.x))
			: mag(13'(sample.y));
		amax = (mag(13'(sample.z)) > amax) ? mag(13'(sample.z)) : amax;
		still_tgt = CNT_W'(still_s(q.mot_dur[7:2]) * SAMPLE_HZ);  // [RQ4]
		stab_tgt  = CNT_W'(ms_to_smp(TILT_STABLE_MS));

		// read mux
		unique case (idx)
			IDX_HIGH_LVL:   rb = q.high_lvl;
			IDX_MOT_DUR:    rb = q.mot_dur;
			IDX_ANY_LVL:    rb = q.any_lvl;
			IDX_STILL_LVL:  rb = q.still_lvl;
			IDX_KNOCK_TIME: rb = q.knock_time;
			IDX_KNOCK_LVL:  rb = q.knock_lvl;
			IDX_TILT_HB:    rb = q.tilt_hb;
			IDX_TILT_UD:    rb = q.tilt_ud;
			IDX_FLAT_ANG:   rb = q.flat_ang;
			IDX_CTRL:       rb = q.ctrl;
			IDX_STATUS:     rb = q.stat;
			IDX_MASK:       rb = q.mask;
			default:        rb = 8'h00;
		endcase
		// read data captured in setup, stands through access
		if (setup) begin
			d.rdata = {24'h0, mapped ? rb : 8'h00};
		end

		// register writes take effect at the access edge; detectors
		// read the new value from the next sample on [RQ19]
		if (acc && pwrite && mapped) begin
			unique case (idx)
				IDX_HIGH_LVL:   d.high_lvl   = wb;
				IDX_MOT_DUR:    d.mot_dur    = wb;
				IDX_ANY_LVL:    d.any_lvl    = wb;
				IDX_STILL_LVL:  d.still_lvl  = wb;
				IDX_KNOCK_TIME: d.knock_time = wb & MSK_KNOCK_TIME;
				IDX_KNOCK_LVL:  d.knock_lvl  = wb & MSK_KNOCK_LVL;
				IDX_TILT_HB:    d.tilt_hb    = wb & MSK_TILT_HB;
				IDX_TILT_UD:    d.tilt_ud    = wb & MSK_TILT_HB;
				IDX_FLAT_ANG:   d.flat_ang   = wb & MSK_SIX_BITS;
				IDX_CTRL:       d.ctrl       = wb & MSK_CTRL;
				IDX_MASK:       d.mask       = wb & MSK_EVENTS;
				default:        d.mask       = q.mask;
			endcase
		end

		// sample evaluation
		if (sample.valid) begin
			d.px        = sample.x;
			d.py        = sample.y;
			d.pz        = sample.z;
			d.have_prev = 1'b1;
			// high-g: any axis above weighted level [RQ1]
			if (amax > weigh(q.high_lvl, SH_HIGH)) begin
				ev[EV_HIGH] = 1'b1;
			end
			if (q.have_prev) begin
				// any-motion: slope above level, duration plus one in a row [RQ6]
				if (smax > weigh(q.any_lvl, SH_SLOPE)) begin
					if (q.any_run >= q.mot_dur[1:0]) begin
						ev[EV_ANY] = 1'b1;  // [RQ5]
					end else begin
						d.any_run = q.any_run + 2'h1;
					end
				end else begin
					d.any_run = 2'h0;
				end
				// stillness detector, mode by select bit [RQ2]
				if (!q.ctrl[CTRL_STILL_NM]) begin
					d.still_cnt = '0;
					if (smax > weigh(q.still_lvl, SH_SLOPE)) begin  // [RQ7]
						if (q.slow_run >= q.mot_dur[3:2]) begin
							ev[EV_STILL] = 1'b1;  // [RQ3]
						end else begin
							d.slow_run = q.slow_run + 2'h1;
						end
					end else begin
						d.slow_run = 2'h0;
					end
				end else begin
					d.slow_run = 2'h0;
					if (smax > weigh(q.still_lvl, SH_SLOPE)) begin  // [RQ7]
						d.still_cnt = '0;
					end else if (q.still_cnt + 1'b1 == still_tgt) begin
						ev[EV_STILL] = 1'b1;  // [RQ4]
						d.still_cnt  = q.still_cnt + 1'b1;
					end else if (q.still_cnt < still_tgt) begin
						d.still_cnt = q.still_cnt + 1'b1;
					end
				end
			end
			// orientation stability count
			if (orient_code != q.orient_prev) begin
				d.stable_cnt = '0;
			end else if (q.stable_cnt < stab_tgt) begin
				d.stable_cnt = q.stable_cnt + 1'b1;
			end
			// blocking apart from the theta angle [RQ14]
			unique case (q.tilt_hb[3:2])
				2'h0: d.tilt.block = 1'b0;
				2'h1: d.tilt.block = amax > by_range(G_1P5_2G, rng);
				2'h2: d.tilt.block = amax > by_range(G_1P5_2G, rng) ||
					(q.have_prev && smax > by_range(G_0P2_2G, rng));
				default: d.tilt.block = amax > by_range(G_1P5_2G, rng) ||
					(q.have_prev && smax > by_range(G_0P4_2G, rng)) ||
					(q.stable_cnt < stab_tgt);
			endcase
		end

		// orientation change event; up/down bit only when enabled; none
		// before the first sample, so reset leaves no false change
		d.orient_prev = orient_code;
		if (q.have_prev && (orient_code[1:0] != q.orient_prev[1:0] ||
			(q.tilt_ud[TU_UD_EN] && orient_code[2] != q.orient_prev[2]))) begin
			ev[EV_TILT] = 1'b1;  // [RQ16]
		end

		// sticky status: a read clears, an event in the same cycle wins
		if (acc && !pwrite && mapped && idx == IDX_STATUS) begin
			d.stat = ev;
		end else begin
			d.stat = q.stat | ev;
		end

		// decoded knock parameters
		d.knock.quiet  = ms_to_smp(q.knock_time[KT_QUIET] ? QUIET_SHORT_MS
			: QUIET_LONG_MS);  // [RQ8]
		d.knock.shock  = ms_to_smp(q.knock_time[KT_SHOCK] ? SHOCK_LONG_MS
			: SHOCK_SHORT_MS);  // [RQ9]
		d.knock.window = ms_to_smp(win_ms(q.knock_time[2:0]));  // [RQ10]
		d.knock.wake_n = 5'(5'h2 << q.knock_lvl[KL_SAMP_LO +: 2]);  // [RQ11]
		d.knock.level  = weigh({4'h0, q.knock_lvl[3:0]}, SH_KNOCK);  // [RQ12]

		// decoded tilt and flat parameters
		d.tilt.hyst  = by_range(weigh({5'h00, q.tilt_hb[6:4]}, SH_HYST), rng);  // [RQ13]
		d.tilt.theta = q.tilt_ud[5:0];   // [RQ17]
		d.tilt.flat  = q.flat_ang[5:0];  // [RQ18]
		unique case (q.tilt_hb[1:0])
			2'h1:    d.tilt.mode = AMIP_TILT_HIGH;  // [RQ15]
			2'h2:    d.tilt.mode = AMIP_TILT_LOW;   // [RQ15]
			default: d.tilt.mode = AMIP_TILT_SYM;   // [RQ15]
		endcase
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST_STATE;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata    = q.rdata;
	assign pready    = clk_en;
	assign pslverr   = psel & penable & ~mapped;
	assign irq       = |(q.stat & q.mask);
	assign knock_cfg = q.knock;
	assign tilt_cfg  = q.tilt;
endmodule

// *** src/amip_pkg.sv ***
// constants, carrier types and register map of the motion parameter bank
// ****************************************************************
// Summary of operation
// RQ1 - high-g level weight doubles with each range
// RQ2 - select bit picks slow-motion or no-motion
// RQ3 - slow-motion after duration plus one samples above
// RQ4 - no-motion after quiet delay in seconds
// RQ5 - any-motion after duration plus one samples above
// RQ6 - any-motion level compares sample-to-sample slope
// RQ7 - stillness level compares sample-to-sample slope
// RQ8 - quiet period 30 ms or 20 ms
// RQ9 - shock period 50 ms or 75 ms
// RQ10 - double-knock window from eight-entry table
// RQ11 - low-power knock sample count 2 to 16
// RQ12 - knock level weight doubles with each range
// RQ13 - tilt hysteresis 62.5 mg in any range
// RQ14 - tilt blocking by code, g and stability
// RQ15 - tilt mode code picks threshold shape
// RQ16 - up/down change raises tilt event when enabled
// RQ17 - tilt blocking angle passed to tilt engine
// RQ18 - flat angle passed to flat detector
// RQ19 - new values apply from next sample
// ****************************************************************
package amip_pkg;
	// ************************************************************
	// register map (printed offsets are word indices)
	// ************************************************************
	localparam int         ADDR_W         = 8;   // apb byte address width
	localparam logic [5:0] IDX_HIGH_LVL   = 6'h26;
	localparam logic [5:0] IDX_MOT_DUR    = 6'h27;
	localparam logic [5:0] IDX_ANY_LVL    = 6'h28;
	localparam logic [5:0] IDX_STILL_LVL  = 6'h29;
	localparam logic [5:0] IDX_KNOCK_TIME = 6'h2A;
	localparam logic [5:0] IDX_KNOCK_LVL  = 6'h2B;
	localparam logic [5:0] IDX_TILT_HB    = 6'h2C;
	localparam logic [5:0] IDX_TILT_UD    = 6'h2D;
	localparam logic [5:0] IDX_FLAT_ANG   = 6'h2E;
	localparam logic [5:0] IDX_CTRL       = 6'h3A;
	localparam logic [5:0] IDX_STATUS     = 6'h3B;
	localparam logic [5:0] IDX_MASK       = 6'h3C;
	// ************************************************************
	// reset values and writable bits
	// ************************************************************
	localparam logic [7:0] RST_HIGH_LVL   = 8'hC0;
	localparam logic [7:0] RST_MOT_DUR    = 8'h00;
	localparam logic [7:0] RST_ANY_LVL    = 8'h14;
	localparam logic [7:0] RST_STILL_LVL  = 8'h14;
	localparam logic [7:0] RST_KNOCK_TIME = 8'h04;
	localparam logic [7:0] RST_KNOCK_LVL  = 8'h0A;
	localparam logic [7:0] RST_TILT_HB    = 8'h18;
	localparam logic [7:0] RST_TILT_UD    = 8'h48;
	localparam logic [7:0] RST_FLAT_ANG   = 8'h08;
	localparam logic [7:0] MSK_KNOCK_TIME = 8'hC7;
	localparam logic [7:0] MSK_KNOCK_LVL  = 8'hDF;
	localparam logic [7:0] MSK_TILT_HB    = 8'h7F;
	localparam logic [7:0] MSK_SIX_BITS   = 8'h3F;
	localparam logic [7:0] MSK_CTRL       = 8'h07;
	localparam logic [7:0] MSK_EVENTS     = 8'h0F;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_RANGE_LO = 0;     // range code, 2 bits
	localparam int CTRL_STILL_NM = 2;     // 1 no-motion, 0 slow-motion
	localparam int EV_HIGH       = 0;     // status / mask bits
	localparam int EV_ANY        = 1;
	localparam int EV_STILL      = 2;
	localparam int EV_TILT       = 3;
	localparam int KT_QUIET      = 7;
	localparam int KT_SHOCK      = 6;
	localparam int KL_SAMP_LO    = 6;
	localparam int TU_UD_EN      = 6;
	// ************************************************************
	// level weights in data lsb (12-bit sample, range scaled)
	// ************************************************************
	localparam int          SH_SLOPE  = 2;         // 3.91 mg per lsb at 2g
	localparam int          SH_HIGH   = 3;         // 7.81 mg per lsb at 2g
	localparam int          SH_KNOCK  = 6;         // 62.5 mg per lsb at 2g
	localparam int          SH_HYST   = 6;         // 62.5 mg per lsb at 2g
	localparam logic [15:0] G_1P5_2G  = 16'h0600;  // 1.5 g at 2g range
	localparam logic [15:0] G_0P2_2G  = 16'h00CD;  // 0.2 g at 2g range
	localparam logic [15:0] G_0P4_2G  = 16'h019A;  // 0.4 g at 2g range
	// ************************************************************
	// times in milliseconds
	// ************************************************************
	localparam int QUIET_LONG_MS  = 30;
	localparam int QUIET_SHORT_MS = 20;
	localparam int SHOCK_SHORT_MS = 50;
	localparam int SHOCK_LONG_MS  = 75;
	localparam int TILT_STABLE_MS = 100;
	localparam int MS_PER_S       = 1000;
	// ************************************************************
	// carrier types
	// ************************************************************
	typedef enum logic [2:0] {
		AMIP_TILT_SYM  = 3'b001,
		AMIP_TILT_HIGH = 3'b010,
		AMIP_TILT_LOW  = 3'b100
	} amip_tilt_mode_e;

	typedef struct packed {
		logic               valid;  // one-cycle sample strobe
		logic signed [11:0] x;
		logic signed [11:0] y;
		logic signed [11:0] z;
	} amip_sample_s;

	typedef struct packed {
		logic [15:0] quiet;    // samples
		logic [15:0] shock;    // samples
		logic [15:0] window;   // samples
		logic [4:0]  wake_n;   // samples after wake-up
		logic [15:0] level;    // data lsb
	} amip_knock_s;

	typedef struct packed {
		amip_tilt_mode_e mode;
		logic [15:0]     hyst;   // data lsb
		logic [5:0]      theta;
		logic [5:0]      flat;
		logic            block;  // g / slope / stability blocking
	} amip_tilt_s;
endpackage

// *** verif/amip_bank_monitor.sv ***
// port checker for the motion parameter bank
`timescale 1ns/100ps
module amip_bank_monitor
	import amip_pkg::*;
#(
	parameter int SAMPLE_HZ = 100  // evaluated samples per second
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              clk_en,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire amip_sample_s      sample,
	input wire logic [2:0]        orient_code,
	input wire logic              irq,
	input wire amip_knock_s       knock_cfg,
	input wire amip_tilt_s        tilt_cfg
);
	// ************************************************************
	// helpers
	// ************************************************************
	logic acc;  // write taken at this edge
	assign acc = psel && penable && pwrite && clk_en;
	// ms to samples, rounded down, never below one
	function automatic int ms2s(int ms);
		return (ms * SAMPLE_HZ < MS_PER_S) ? 1 : ms * SAMPLE_HZ / MS_PER_S;
	endfunction
	// mode code to one-hot shape
	function automatic amip_tilt_mode_e mode_of(logic [1:0] c);
		return (c == 2'b01) ? AMIP_TILT_HIGH : (c == 2'b10) ? AMIP_TILT_LOW : AMIP_TILT_SYM;
	endfunction
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ************************************************************
	// assertions
	// ************************************************************
	a_ready_en: assert property (pready == clk_en)
		else $error("pready not enable");
	a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr && prdata == 0)
		else $error("misalign taken");
	a_err_mapped: assert property (psel && penable && paddr == {IDX_FLAT_ANG, 2'b00} |-> !pslverr)
		else $error("mapped access refused");
	a_knock_time: assert property (acc && paddr == {IDX_KNOCK_TIME, 2'b00} ##1 clk_en |=>
		knock_cfg.quiet == 16'(ms2s($past(pwdata[KT_QUIET], 2) ? QUIET_SHORT_MS
			: QUIET_LONG_MS)) &&
		knock_cfg.shock == 16'(ms2s($past(pwdata[KT_SHOCK], 2) ? SHOCK_LONG_MS
			: SHOCK_SHORT_MS)))
		else $error("quiet or shock wrong");
	a_knock_wake: assert property (acc && paddr == {IDX_KNOCK_LVL, 2'b00} ##1 clk_en |=>
		knock_cfg.wake_n == 5'd2 << $past(pwdata[7:6], 2))
		else $error("wake count wrong");
	a_tilt_mode: assert property (acc && paddr == {IDX_TILT_HB, 2'b00} ##1 clk_en |=>
		tilt_cfg.mode == mode_of($past(pwdata[1:0], 2)))
		else $error("tilt mode wrong");
	a_tilt_theta: assert property (acc && paddr == {IDX_TILT_UD, 2'b00} ##1 clk_en |=>
		tilt_cfg.theta == $past(pwdata[5:0], 2))
		else $error("blocking angle wrong");
	a_irq_masked: assert property (acc && paddr == {IDX_MASK, 2'b00} && pwdata[3:0] == 4'h0
		##1 clk_en |=> !irq)
		else $error("irq while masked");
endmodule
bind amip_bank amip_bank_monitor #(.SAMPLE_HZ(SAMPLE_HZ)) u_mon (.*);

// *** verif/amip_host.sv ***
// apb master standing in for the host processor
`timescale 1ns/100ps
module amip_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// bus idle from time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end
	// one transfer, begun just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e, output logic ok);
		int n = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// hold until pready at an edge, bounded
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r  = prdata;
		e  = pslverr;
		ok = (pready === 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines show the inverse
		paddr   <= ~a;
		pwdata  <= ~d;
		@(posedge pclk);
	endtask
endmodule

// *** verif/tb.sv ***
// self-checking testbench for the motion parameter bank
`timescale 1ns/100ps
module tb;
	import amip_pkg::*;
	logic         pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, err, ok;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [2:0]   orient_code;
	amip_sample_s sample;
	amip_knock_s  knock_cfg;
	amip_tilt_s   tilt_cfg;
	int           mismatches, cmp_count;
	// index, reset value, bits kept after an all-ones write
	localparam logic [5:0] IDX_T [11] = '{IDX_HIGH_LVL, IDX_MOT_DUR, IDX_ANY_LVL, IDX_STILL_LVL,
		IDX_KNOCK_TIME, IDX_KNOCK_LVL, IDX_TILT_HB, IDX_TILT_UD, IDX_FLAT_ANG, IDX_CTRL, IDX_MASK};
	localparam logic [7:0] RST_T [11] = '{RST_HIGH_LVL, RST_MOT_DUR, RST_ANY_LVL, RST_STILL_LVL,
		RST_KNOCK_TIME, RST_KNOCK_LVL, RST_TILT_HB, RST_TILT_UD, RST_FLAT_ANG, 8'h00, 8'h00};
	localparam logic [7:0] MSK_T [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, MSK_KNOCK_TIME,
		MSK_KNOCK_LVL, MSK_TILT_HB, 8'h7F, MSK_SIX_BITS, MSK_CTRL, MSK_EVENTS};
	localparam amip_tilt_mode_e MODE_T [4] = '{AMIP_TILT_SYM, AMIP_TILT_HIGH, AMIP_TILT_LOW,
		AMIP_TILT_SYM};
	localparam int WIN_T [8] = '{5, 10, 15, 20, 25, 37, 50, 70};  // window in samples at 100 Hz
	localparam logic [7:0] RUN_T [4] = '{8'h00, 8'h04, 8'h04, 8'h06};
	localparam logic [7:0] NM_D [3] = '{8'h04, 8'h40, 8'h80};     // 2 s, 20 s, 88 s
	localparam int NM_N [3] = '{200, 2000, 8800};                 // the same in samples
	amip_bank #(.SAMPLE_HZ(100)) dut (.*);
	amip_host host (.*);
	// 10 MHz clock
	always #50 pclk = ~pclk;
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// one register access; a hung bus ends the run
	task automatic rw(input logic w, input logic [5:0] idx, input logic [7:0] d);
		host.xfer(w, {idx, 2'b00}, {24'h0, d}, rd, err, ok);
		if (!ok) begin
			mismatches++;
			$display("BAD t=%0t bus hung", $time);
			test_done();
		end
	endtask
	// read and compare one register
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
		rw(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp}, "rdata");
		chk({31'h0, err}, 32'h0, "refused");
	endtask
	// one x-axis sample strobe
	task automatic send(input logic [11:0] x);
		sample.valid <= 1'b1;
		sample.x     <= x;
		@(posedge pclk);
		sample.valid <= 1'b0;
		sample.x     <= ~x;
		@(posedge pclk);
	endtask
	// interrupt level at a settled point
	task automatic irqchk(input logic exp);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, exp}, "irq");
		@(posedge pclk);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		clk_en = 1'b1;
		orient_code = 3'b000;
		sample = '0;
		mismatches = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values, writable bits, refused accesses
		rdchk(IDX_STATUS, 8'h00);
		for (int i = 0; i < 11; i++) begin
			rdchk(IDX_T[i], RST_T[i]);
			rw(1'b1, IDX_T[i], 8'hFF);
			rdchk(IDX_T[i], MSK_T[i]);
			rw(1'b1, IDX_T[i], RST_T[i]);
		end
		host.xfer(1'b1, 8'h99, 32'h55, rd, err, ok);
		chk({31'h0, err}, 32'h1, "misalign");
		rw(1'b0, 6'h30, 8'h00);
		chk({31'h0, err}, 32'h1, "unmapped");
		rdchk(IDX_HIGH_LVL, RST_HIGH_LVL);
		$display("test registers done");
		// knock decode, every time and wake code, level codes 0 to 7
		for (int i = 0; i < 8; i++) begin
			rw(1'b1, IDX_KNOCK_TIME, {i[0], i[1], 3'b000, i[2:0]});
			rw(1'b1, IDX_KNOCK_LVL, {i[1:0], 3'b000, i[2:0]});
			@(negedge pclk);
			chk(knock_cfg.quiet, i[0] ? 32'd2 : 32'd3, "quiet");
			chk(knock_cfg.shock, i[1] ? 32'd7 : 32'd5, "shock");
			chk(knock_cfg.window, WIN_T[i], "window");
			chk(knock_cfg.wake_n, 32'd2 << i[1:0], "wake");
			chk(knock_cfg.level, 32'(i * 64), "level");
			@(posedge pclk);
		end
		// tilt modes, hysteresis in two ranges, angles
		for (int i = 0; i < 4; i++) begin
			rw(1'b1, IDX_TILT_HB, {1'b0, 3'(i + 1), i[1:0], i[1:0]});
			@(negedge pclk);
			chk({29'h0, tilt_cfg.mode}, {29'h0, MODE_T[i]}, "mode");
			chk(tilt_cfg.hyst, 32'((i + 1) * 64), "hyst");
			@(posedge pclk);
		end
		rw(1'b1, IDX_CTRL, 8'h01);
		rw(1'b1, IDX_TILT_UD, 8'h2D);
		rw(1'b1, IDX_FLAT_ANG, 8'h3F);
		@(negedge pclk);
		chk(tilt_cfg.hyst, 32'd128, "hyst 4g");
		chk(tilt_cfg.theta, 32'h2D, "theta");
		chk(tilt_cfg.flat, 32'h3F, "flat");
		@(posedge pclk);
		rw(1'b1, IDX_CTRL, 8'h00);
		$display("test decode done");
		// motion levels, masking, read clear
		rw(1'b1, IDX_MASK, 8'h02);
		send(12'd0);
		send(12'd0);
		rw(1'b0, IDX_STATUS, 8'h00);
		send(12'd200);
		irqchk(1'b1);
		rdchk(IDX_STATUS, 8'h06);
		irqchk(1'b0);
		send(12'd280);
		rdchk(IDX_STATUS, 8'h00);
		send(12'd361);
		rdchk(IDX_STATUS, 8'h06);
		rw(1'b1, IDX_MASK, 8'h00);
		send(12'd0);
		irqchk(1'b0);
		rdchk(IDX_STATUS, 8'h06);
		// run lengths four and two
		rw(1'b1, IDX_MOT_DUR, 8'h07);
		send(12'd0);
		for (int k = 0; k < 4; k++) begin
			send(k[0] ? 12'd0 : 12'd200);
			rdchk(IDX_STATUS, RUN_T[k]);
		end
		// no-motion delay, three encodings
		rw(1'b1, IDX_CTRL, 8'h04);
		for (int j = 0; j < 3; j++) begin
			rw(1'b1, IDX_MOT_DUR, NM_D[j]);
			send(12'd0);
			send(12'd300);
			rw(1'b0, IDX_STATUS, 8'h00);
			repeat (NM_N[j] - 1) send(12'd300);
			rdchk(IDX_STATUS, 8'h00);
			send(12'd300);
			rdchk(IDX_STATUS, 8'h04);
		end
		$display("test motion done");
		// large acceleration boundary, two ranges
		rw(1'b1, IDX_CTRL, 8'h00);
		rw(1'b1, IDX_MOT_DUR, 8'h00);
		rw(1'b1, IDX_MASK, 8'h01);
		send(12'd1536);
		rdchk(IDX_STATUS, 8'h06);
		send(12'd1537);
		irqchk(1'b1);
		rdchk(IDX_STATUS, 8'h01);
		rw(1'b1, IDX_CTRL, 8'h03);
		send(12'd1537);
		chk({31'h0, tilt_cfg.block}, 32'h1, "block");
		rdchk(IDX_STATUS, 8'h01);
		// tilt change, up/down ignored then enabled
		rw(1'b1, IDX_MASK, 8'h08);
		orient_code <= 3'b001;
		@(posedge pclk);
		irqchk(1'b1);
		rdchk(IDX_STATUS, 8'h08);
		orient_code <= 3'b101;
		@(posedge pclk);
		rdchk(IDX_STATUS, 8'h00);
		rw(1'b1, IDX_TILT_UD, 8'h6D);
		orient_code <= 3'b001;
		@(posedge pclk);
		rdchk(IDX_STATUS, 8'h08);
		$display("test events done");
		// frozen clock enable, then a second reset
		clk_en <= 1'b0;
		send(12'd0);
		clk_en <= 1'b1;
		@(posedge pclk);
		rdchk(IDX_STATUS, 8'h00);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(IDX_TILT_UD, RST_TILT_UD);
		rdchk(IDX_STATUS, 8'h00);
		@(negedge pclk);
		chk(tilt_cfg.hyst, 32'd64, "hyst reset");
		$display("test freeze and reset done");
		test_done();
	end
endmodule
